// ==== verilog/slc_line_codec.sv ====
// Serial line coder, decoder and DPLL clock recovery for one channel.
//
// The strobed register port and the address map were chosen for this implementation.
`timescale 1ns/10ps
module slc_line_codec #(
    parameter int DIV_W = slc_pkg::DIV_WIDTH
) (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic rst_n,
    // Register port.
    input wire logic [7:0] regAddr,
    input wire logic [31:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    output logic [31:0] regRdData,
    // Line side pins.
    input wire logic rxLine,
    input wire logic rxClkPin,
    output logic txLine,
    output logic txClkOut,
    output logic rxClkOut
);
    import slc_pkg::*;

    // ***********************************************************
    // State record.
    // ***********************************************************
    typedef struct packed {
        logic [2:0] coding;
        logic asyncMode;
        logic txEn;
        logic rxEn;
        logic [1:0] rxSrc;
        logic [2:0] txSrc;
        logic [DIV_W-1:0] baudDiv;
        logic [31:0] rdData;
        slc_tx_state_t txState;
        logic [31:0] txWord;
        logic [4:0] txBitCnt;
        logic txBit;
        logic txLine;
        logic txClk;
        logic [3:0] txPh;
        logic [3:0] dpllPh;
        logic locked;
        logic [7:0] quietCnt;
        logic rxClk;
        logic [1:0] rxSync;
        logic rxPrev;
        logic [1:0] ckSync;
        logic ckPrev;
        logic firstHalf;
        logic center;
        logic lastLevel;
        logic [31:0] rxWord;
        logic [4:0] rxBitCnt;
        logic [31:0] rxOut;
        logic rxValid;
        logic overrun;
    } slc_core_t;

    slc_core_t q;
    slc_core_t d;
    logic tick16;

    initial begin
        if (DIV_W < 4 || DIV_W > 31) begin
            $error("slc_line_codec: DIV_W out of range");
        end
    end

    // ***********************************************************
    // Reference clock divider.
    // ***********************************************************
    slc_baud_divider #(
        .DIV_W(DIV_W)
    ) u_div (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .divisor(q.baudDiv),
        .tick(tick16)
    );

    // ***********************************************************
    // Next-state logic.
    // ***********************************************************
    logic [2:0] effCode;
    logic [3:0] curTxPh;
    logic txStart;
    logic txMid;
    logic newBit;
    logic rxEdge;
    logic rxLevel;
    logic ckRise;
    logic bitStrobe;
    logic bitVal;
    logic [31:0] shifted;

    // Coding, phase and edge terms used throughout the update.
    always_comb begin
        // Async character mode forces NRZ whatever the coding field says.
        effCode = q.asyncMode ? CODE_NRZ : q.coding;
        // DPLL transmit clock runs a quarter cell ahead of receive.
        if (q.txSrc == TCS_DPLL) begin
            curTxPh = q.dpllPh + PH_QUARTER;
        end else begin
            curTxPh = q.txPh;
        end
        txStart = tick16 && (curTxPh == 4'h0);
        txMid = tick16 && (curTxPh == PH_MID);
        rxLevel = q.rxSync[1];
        rxEdge = rxLevel ^ q.rxPrev;
        ckRise = q.ckSync[1] & ~q.ckPrev;
    end

    // Whole block update.
    always_comb begin
        d = q;
        d.rdData = 32'h00000000;
        newBit = 1'b1;
        bitStrobe = 1'b0;
        bitVal = 1'b0;
        shifted = 32'h00000000;

        // Two-flop synchronisers for the line and clock pins.
        d.rxSync = {q.rxSync[0], rxLine};
        d.rxPrev = q.rxSync[1];
        d.ckSync = {q.ckSync[0], rxClkPin};
        d.ckPrev = q.ckSync[1];

        // Register writes.
        if (regWr) begin
            case (regAddr)
                OFS_CTRL: begin
                    d.coding = regWrData[2:0];
                    d.asyncMode = regWrData[POS_ASYNC];
                    d.txEn = regWrData[POS_TXEN];
                    d.rxEn = regWrData[POS_RXEN];
                end
                OFS_CLKSRC: begin
                    d.rxSrc = regWrData[POS_RXSRC +: 2];
                    d.txSrc = regWrData[POS_TXSRC +: 3];
                end
                OFS_BAUD: begin
                    d.baudDiv = regWrData[DIV_W-1:0];
                end
                OFS_TXDATA: begin
                    // A word is taken only while idle and enabled.
                    if (q.txEn && q.txState == TX_IDLE) begin
                        d.txWord = regWrData;
                        d.txBitCnt = 5'h00;
                        d.txState = TX_SEND;
                    end
                end
                OFS_STATUS: begin
                    if (regWrData[POS_OVERRUN]) begin
                        d.overrun = 1'b0;
                    end
                end
                default: begin
                end
            endcase
        end

        // Register reads; data stand only in the following cycle.
        if (regRd) begin
            case (regAddr)
                OFS_CTRL: begin
                    d.rdData = {26'h0000000, q.rxEn, q.txEn,
                        q.asyncMode, q.coding};
                end
                OFS_CLKSRC: begin
                    d.rdData = {25'h0000000, q.txSrc, 2'h0, q.rxSrc};
                end
                OFS_BAUD: begin
                    d.rdData = {{(32 - DIV_W){1'b0}}, q.baudDiv};
                end
                OFS_RXDATA: begin
                    d.rdData = q.rxOut;
                    d.rxValid = 1'b0;
                end
                OFS_STATUS: begin
                    d.rdData = {28'h0000000, q.overrun, q.locked,
                        q.rxValid, (q.txState == TX_SEND)};
                end
                default: begin
                    d.rdData = 32'h00000000;
                end
            endcase
        end

        // Free-running divide-by-sixteen transmit cell phase.
        if (tick16) begin
            d.txPh = q.txPh + 4'h1;
        end

        // Transmit: load a bit at cell start, lowest bit first.
        if (txStart) begin
            if (q.txState == TX_SEND) begin
                newBit = q.txWord[0];
                d.txWord = {1'b0, q.txWord[31:1]};
                d.txBitCnt = q.txBitCnt + 5'h01;
                if (q.txBitCnt == 5'h1f) begin
                    d.txState = TX_IDLE;
                end
            end
            d.txBit = newBit;
            case (effCode)
                CODE_NRZ: d.txLine = newBit;
                CODE_NRZI: d.txLine = q.txLine ^ ~newBit;
                CODE_FM0: d.txLine = ~q.txLine;
                CODE_FM1: d.txLine = ~q.txLine;
                CODE_MAN: d.txLine = newBit;
                default: d.txLine = newBit;
            endcase
        end else if (txMid) begin
            // Mid-cell edges of the biphase codings.
            case (effCode)
                CODE_FM0: d.txLine = q.txLine ^ ~q.txBit;
                CODE_FM1: d.txLine = q.txLine ^ q.txBit;
                CODE_MAN: d.txLine = ~q.txBit;
                default: d.txLine = q.txLine;
            endcase
        end
        if (tick16) begin
            d.txClk = (curTxPh >= PH_MID);
        end

        // DPLL phase: resync on a line edge, else count the reference.
        if (tick16) begin
            d.dpllPh = q.dpllPh + 4'h1;
            if (q.quietCnt == LOCK_TICKS) begin
                d.locked = 1'b0;
            end else begin
                d.quietCnt = q.quietCnt + 8'h01;
            end
        end
        if (rxEdge && q.rxSrc == RCS_DPLL) begin
            if (!q.locked) begin
                // First edge after losing lock is taken as a boundary.
                d.dpllPh = 4'h0;
                d.locked = 1'b1;
                d.quietCnt = 8'h00;
            end else if (effCode == CODE_MAN) begin
                // Manchester always has a mid-cell edge; track on it.
                if (q.dpllPh >= PH_FIRST && q.dpllPh < PH_LATE) begin
                    d.dpllPh = PH_MID;
                    d.quietCnt = 8'h00;
                end
            end else if (q.dpllPh >= PH_LATE || q.dpllPh < PH_FIRST) begin
                // Other codings track on the cell boundary edge.
                d.dpllPh = 4'h0;
                d.quietCnt = 8'h00;
            end
        end
        if (tick16) begin
            d.rxClk = (q.dpllPh >= PH_MID);
        end

        // Receive sampling at quarter, centre and three-quarter phase.
        if (q.rxSrc == RCS_DPLL) begin
            if (tick16 && q.dpllPh == PH_FIRST) begin
                d.firstHalf = rxLevel;
            end
            if (tick16 && q.dpllPh == PH_MID) begin
                d.center = rxLevel;
            end
            if (tick16 && q.dpllPh == PH_LATE) begin
                bitStrobe = 1'b1;
                case (effCode)
                    CODE_NRZ: bitVal = q.center;
                    CODE_NRZI: bitVal = ~(q.center ^ q.lastLevel);
                    CODE_FM0: bitVal = ~(q.firstHalf ^ rxLevel);
                    CODE_FM1: bitVal = q.firstHalf ^ rxLevel;
                    CODE_MAN: bitVal = q.firstHalf;
                    default: bitVal = q.center;
                endcase
                d.lastLevel = q.center;
            end
        end else if (ckRise) begin
            // External receive clock: level codings only.
            bitStrobe = 1'b1;
            bitVal = (effCode == CODE_NRZI) ?
                ~(rxLevel ^ q.lastLevel) : rxLevel;
            d.lastLevel = rxLevel;
        end

        // Pack bits lowest first; earlier bytes land in lower lanes.
        if (bitStrobe && q.rxEn) begin
            shifted = {bitVal, q.rxWord[31:1]};
            d.rxWord = shifted;
            d.rxBitCnt = q.rxBitCnt + 5'h01;
            if (q.rxBitCnt == 5'h1f) begin
                d.rxOut = shifted;
                // A new word wins over a read clear in the same cycle.
                d.rxValid = 1'b1;
                if (q.rxValid) begin
                    d.overrun = 1'b1;
                end
            end
        end
        if (!q.rxEn) begin
            d.rxBitCnt = 5'h00;
        end
    end

    // ***********************************************************
    // State register.
    // ***********************************************************
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
            q.baudDiv <= RST_BAUD[DIV_W-1:0];
            q.txSrc <= TCS_BRG16;
            q.txBit <= 1'b1;
            q.txLine <= 1'b1;
            q.rxSync <= 2'h3;
            q.rxPrev <= 1'b1;
        end else begin
            q <= d;
        end
    end

    // Outputs straight from the state register.
    assign regRdData = q.rdData;
    assign txLine = q.txLine;
    assign txClkOut = q.txClk;
    assign rxClkOut = q.rxClk;

endmodule

// ==== verilog/slc_pkg.sv ====
// Constants and types shared by the serial line codec files.
// ***************************************************************
// Notes on behaviour
// - Five line codings selectable, for transmit and for receive.
// - Asynchronous character mode always uses NRZ coding.
// - NRZ: line level equals the bit; received level is the bit.
// - NRZI: zero is a transition at cell start, one is none.
// - FM0: edge every cell start, extra mid-cell edge for zero.
// - FM1: edge every cell start, extra mid-cell edge for one.
// - Manchester: bit in first half, inverted level in second half.
// - Biphase codings: transmit clock leads receive clock by 90 deg.
// - Biphase receive clock is regenerated from data by the DPLL.
// - DPLL keeps adjusting its phase to sample bits at the best point.
// - Transmit clock is divider over sixteen or DPLL transmit clock.
// - DPLL tracking method depends on the selected line coding.
// - Words are little endian; byte 0 is the least significant.
// - Transmit words send lower bytes first.
// - Received bytes pack earlier ones into lower byte positions.
// - Divider output equals input clock divided by programmable k.
// - Receive and transmit clock sources share one config register.
// ***************************************************************
package slc_pkg;

    // ***********************************************************
    // Register map and field layout.
    // ***********************************************************
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_CLKSRC = 8'h04;
    localparam logic [7:0] OFS_BAUD = 8'h08;
    localparam logic [7:0] OFS_TXDATA = 8'h0c;
    localparam logic [7:0] OFS_RXDATA = 8'h10;
    localparam logic [7:0] OFS_STATUS = 8'h14;
    localparam int POS_ASYNC = 3;
    localparam int POS_TXEN = 4;
    localparam int POS_RXEN = 5;
    localparam int POS_RXSRC = 0;
    localparam int POS_TXSRC = 4;
    localparam int POS_OVERRUN = 3;
    localparam int DIV_WIDTH = 21;
    localparam logic [20:0] RST_BAUD = 21'h00000f;

    // ***********************************************************
    // Codings and clock source codes.
    // ***********************************************************
    typedef enum logic [2:0] {
        CODE_NRZ = 3'h0,
        CODE_NRZI = 3'h1,
        CODE_FM0 = 3'h2,
        CODE_FM1 = 3'h3,
        CODE_MAN = 3'h4
    } slc_coding_t;
    localparam logic [1:0] RCS_DPLL = 2'h2;
    localparam logic [2:0] TCS_DPLL = 3'h3;
    localparam logic [2:0] TCS_BRG16 = 3'h4;

    // ***********************************************************
    // Bit cell timing in reference ticks (sixteen per cell).
    // ***********************************************************
    localparam logic [3:0] PH_FIRST = 4'h4;
    localparam logic [3:0] PH_MID = 4'h8;
    localparam logic [3:0] PH_LATE = 4'hc;
    localparam logic [3:0] PH_QUARTER = 4'h4;
    localparam logic [7:0] LOCK_TICKS = 8'h40;

    typedef enum logic [0:0] {
        TX_IDLE = 1'b0,
        TX_SEND = 1'b1
    } slc_tx_state_t;

endpackage

// ==== verilog/slc_baud_divider.sv ====
// Programmable divider that makes the sixteen-times reference tick.
`timescale 1ns/10ps
module slc_baud_divider #(
    parameter int DIV_W = slc_pkg::DIV_WIDTH
) (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic rst_n,
    // Divisor minus one, and the output tick.
    input wire logic [DIV_W-1:0] divisor,
    output logic tick
);
    import slc_pkg::*;

    typedef struct packed {
        logic [DIV_W-1:0] count;
        logic tick;
    } slc_div_t;

    slc_div_t q;
    slc_div_t d;

    initial begin
        if (DIV_W < 4 || DIV_W > 31) begin
            $error("slc_baud_divider: DIV_W out of range");
        end
    end

    // One tick every divisor plus one clocks, so k = divisor + 1.
    always_comb begin
        d = q;
        d.tick = 1'b0;
        if (q.count >= divisor) begin
            d.count = '0;
            d.tick = 1'b1;
        end else begin
            d.count = q.count + 1'b1;
        end
    end

    // State register.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign tick = q.tick;

endmodule

// ==== testbench/slc_line_codec_sva.sv ====
// Port checker for the serial line codec, bound to its top module.
`timescale 1ns/10ps
module slc_checker #(
    parameter int DIV_W = slc_pkg::DIV_WIDTH
) (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic rst_n,
    // Register port.
    input wire logic [7:0] regAddr,
    input wire logic [31:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    input wire logic [31:0] regRdData,
    // Line side pins.
    input wire logic rxLine,
    input wire logic rxClkPin,
    input wire logic txLine,
    input wire logic txClkOut,
    input wire logic rxClkOut
);
    import slc_pkg::*;
    // ********************
    // Configuration shadow
    // ********************
    logic [5:0] ctrlQ;
    logic [5:0] ctrlP;
    logic [6:0] srcQ;
    logic [20:0] baudQ;
    logic [5:0] ageQ;
    logic txOn, nrzOn, brgOn, dpllOn;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    // Follows writes so the properties know coding and clock source.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrlQ <= 6'h00;
            ctrlP <= 6'h00;
            srcQ <= 7'h40;
            baudQ <= RST_BAUD;
            ageQ <= 6'h00;
        end else begin
            // Line edges seen now were coded with the previous setting.
            ctrlP <= ctrlQ;
            if (regWr && regAddr == OFS_CTRL) ctrlQ <= regWrData[5:0];
            if (regWr && regAddr == OFS_CLKSRC) srcQ <= regWrData[6:0] & 7'h73;
            if (regWr && regAddr == OFS_BAUD) baudQ <= regWrData[20:0];
            if (regWr && (regAddr == OFS_CLKSRC || regAddr == OFS_BAUD)) begin
                ageQ <= 6'h00;
            end else if (ageQ != 6'h3f) begin
                ageQ <= ageQ + 6'h01;
            end
        end
    end
    // Transmitter modes as seen from the shadow.
    assign txOn = ctrlP[4] && srcQ[6:4] != TCS_DPLL && !ctrlP[3];
    assign nrzOn = ctrlP[4] && srcQ[6:4] != TCS_DPLL && (ctrlP[3]
        || ctrlP[2:0] == CODE_NRZ || ctrlP[2:0] > 3'h4);
    assign brgOn = srcQ[6:4] != TCS_DPLL && baudQ == 21'h0 && ageQ >= 6'h20;
    assign dpllOn = srcQ[6:4] == TCS_DPLL && srcQ[1:0] == RCS_DPLL
        && baudQ == 21'h0 && ageQ >= 6'h20;
    sequence sWrBaud;
        regWr && regAddr == OFS_BAUD;
    endsequence
    sequence sRdBaud;
        regRd && regAddr == OFS_BAUD;
    endsequence
    sequence sWrSrc;
        regWr && regAddr == OFS_CLKSRC;
    endsequence
    sequence sRdSrc;
        regRd && regAddr == OFS_CLKSRC;
    endsequence
    property pCellOnly(logic en);
        en && $changed(txLine) |-> $fell(txClkOut);
    endproperty
    AST_BAUD_READBACK: assert property (
        sWrBaud ##2 sRdBaud |=> regRdData == ($past(regWrData, 3) & 32'h001fffff))
        else $error("Divider read back differs from the written value.");
    AST_CLKSRC_READBACK: assert property (
        sWrSrc ##2 sRdSrc |=> regRdData == ($past(regWrData, 3) & 32'h00000073))
        else $error("Clock source read back differs from the written value.");
    AST_NRZ_CELL_EDGE: assert property (pCellOnly(nrzOn))
        else $error("Plain level coding changed the line inside a cell.");
    AST_NRZI_CELL_EDGE: assert property (
        pCellOnly(txOn && ctrlP[2:0] == CODE_NRZI))
        else $error("Inverted level coding changed the line inside a cell.");
    AST_FM_START_EDGE: assert property (
        txOn && (ctrlP[2:0] == CODE_FM0 || ctrlP[2:0] == CODE_FM1)
        && $fell(txClkOut) |-> $changed(txLine))
        else $error("Biphase cell started without a line edge.");
    AST_MAN_MID_EDGE: assert property (
        txOn && ctrlP[2:0] == CODE_MAN && $rose(txClkOut) |-> $changed(txLine))
        else $error("Split phase cell lacks its centre inversion.");
    AST_BRG16_PERIOD: assert property (
        brgOn && $rose(txClkOut) |-> ##16 ($rose(txClkOut) || ageQ < 6'h10))
        else $error("Transmit clock is not the reference over sixteen.");
    AST_DPLL_LEAD: assert property (
        dpllOn && $rose(txClkOut) |-> ##[1:11] ($rose(rxClkOut) || ageQ < 6'h10))
        else $error("Transmit clock does not lead the recovered clock.");
endmodule
bind slc_line_codec slc_checker #(.DIV_W(DIV_W)) chk (.sys_clk(sys_clk),
    .rst_n(rst_n), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
    .regRd(regRd), .regRdData(regRdData), .rxLine(rxLine),
    .rxClkPin(rxClkPin), .txLine(txLine), .txClkOut(txClkOut),
    .rxClkOut(rxClkOut));

// ==== testbench/slc_remote_station.sv ====
// Remote serial station that codes words onto the receive line.
`timescale 1ns/10ps
module slc_remote_station (
    // Clock.
    input wire logic sys_clk,
    // Line pins towards the codec.
    output logic rxLine,
    output logic rxClkPin
);
    import slc_pkg::*;
    logic lastLv;
    // The line starts high and keeps its last level between frames; the clock pin stands still outside frames.
    initial begin
        rxLine = 1'b1;
        rxClkPin = 1'b0;
        lastLv = 1'b1;
    end
    // Returns first and second half levels of one cell.
    function automatic logic [1:0] cell_lv(logic [2:0] c, logic b, logic l);
        logic f;
        case (c)
            CODE_NRZI: f = b ? l : ~l;
            CODE_FM0, CODE_FM1: f = ~l;
            default: f = b;
        endcase
        case (c)
            CODE_FM0: return {f, b ? f : ~f};
            CODE_FM1: return {f, b ? ~f : f};
            CODE_MAN: return {f, ~f};
            default: return {f, f};
        endcase
    endfunction
    // Sends n cells of sixteen clocks, pulsing the clock pin if asked.
    task automatic send(logic [2:0] c, logic [31:0] w, int n, logic withClk);
        logic [1:0] lv;
        for (int i = 0; i < n; i++) begin
            lv = cell_lv(c, w[i % 32], lastLv);
            rxLine <= lv[1];
            repeat (8) @(posedge sys_clk);
            rxLine <= lv[0];
            rxClkPin <= withClk;
            repeat (8) @(posedge sys_clk);
            rxClkPin <= 1'b0;
            lastLv = lv[0];
        end
    endtask
endmodule

// ==== testbench/slc_line_codec_bench.sv ====
// Self-checking bench for the serial line codec.
`timescale 1ns/10ps
module slc_line_codec_bench;
    import slc_pkg::*;
    localparam logic [31:0] WORD = 32'h3c5a96e1;
    logic sysClk = 1'b0;
    logic rstN = 1'b0;
    logic [7:0] regAddr = 8'h00;
    logic [31:0] regWrData = 32'h0;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic [31:0] regRdData, rdVal;
    logic rxLine, rxClkPin, txLine, txClkOut, rxClkOut;
    int errTotal = 0;
    int nTests = 0;
    int cycles = 0;
    // Free running clock of 5 ns period.
    always #2.5 sysClk = ~sysClk;
    slc_line_codec DUT (.sys_clk(sysClk), .rst_n(rstN), .regAddr(regAddr),
        .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
        .regRdData(regRdData), .rxLine(rxLine), .rxClkPin(rxClkPin),
        .txLine(txLine), .txClkOut(txClkOut), .rxClkOut(rxClkOut));
    slc_remote_station remote (.sys_clk(sysClk), .rxLine(rxLine),
        .rxClkPin(rxClkPin));
    // Prints the counts and the verdict, then ends the run.
    task automatic reportAndStop();
        $display("Comparisons %0d, mismatches %0d", nTests, errTotal);
        if (errTotal == 0 && nTests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // Compares one result and counts it.
    task automatic chk(logic [31:0] got, logic [31:0] exp);
        nTests++;
        if (got !== exp) begin
            errTotal++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One write cycle, normally followed by an idle cycle.
    task automatic wr(logic [7:0] a, logic [31:0] d, bit gap = 1'b1);
        regWr <= 1'b1;
        regAddr <= a;
        regWrData <= d;
        @(posedge sysClk);
        regWr <= 1'b0;
        if (gap) @(posedge sysClk);
    endtask
    // One read cycle; the data are taken in the cycle after it.
    task automatic rdChk(logic [7:0] a, logic [31:0] m, logic [31:0] e);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge sysClk);
        regRd <= 1'b0;
        #1 rdVal = regRdData;
        chk(rdVal & m, e);
        @(posedge sysClk);
    endtask
    // Sends a word and checks both half cells of every bit on the line.
    task automatic txRun(logic [2:0] c, logic async);
        logic f, s, prev, lastLv;
        logic [1:0] lv;
        int n = 0;
        wr(OFS_CTRL, {26'h0, 1'b0, 1'b1, async, c});
        wr(OFS_TXDATA, WORD, 1'b0);
        #1;
        do begin
            prev = txClkOut;
            lastLv = txLine;
            @(posedge sysClk);
            #1 n++;
        end while (!(prev && !txClkOut) && n < 40);
        chk({31'h0, prev && !txClkOut}, 32'h1);
        for (int i = 0; i < 32; i++) begin
            lv = remote.cell_lv(async ? CODE_NRZ : c, WORD[i], lastLv);
            repeat (4) @(posedge sysClk);
            #1 f = txLine;
            repeat (8) @(posedge sysClk);
            #1 s = txLine;
            chk({30'h0, f, s}, {30'h0, lv});
            lastLv = s;
            repeat (4) @(posedge sysClk);
        end
        repeat (20) @(posedge sysClk);
        rdChk(OFS_STATUS, 32'h1, 32'h0);
    endtask
    // Main sequence of register, transmit and receive tests.
    initial begin
        repeat (20) @(posedge sysClk);
        rstN <= 1'b1;
        @(posedge sysClk);
        rdChk(OFS_CTRL, 32'hffffffff, 32'h0);
        rdChk(OFS_CLKSRC, 32'hffffffff, 32'h40);
        rdChk(OFS_BAUD, 32'hffffffff, 32'hf);
        rdChk(OFS_STATUS, 32'hffffffff, 32'h0);
        rdChk(8'h18, 32'hffffffff, 32'h0);
        wr(OFS_BAUD, 32'hffffffff);
        rdChk(OFS_BAUD, 32'hffffffff, 32'h001fffff);
        wr(OFS_BAUD, 32'h0);
        rdChk(OFS_BAUD, 32'hffffffff, 32'h0);
        for (int c = 0; c < 5; c++) begin
            txRun(c[2:0], 1'b0);
        end
        txRun(CODE_MAN, 1'b1);
        wr(OFS_CTRL, 32'h0);
        wr(OFS_TXDATA, WORD);
        rdChk(OFS_STATUS, 32'h1, 32'h0);
        wr(OFS_CTRL, 32'h20);
        remote.send(CODE_NRZ, WORD, 32, 1'b1);
        repeat (20) @(posedge sysClk);
        rdChk(OFS_STATUS, 32'h2, 32'h2);
        rdChk(OFS_RXDATA, 32'hffffffff, WORD);
        rdChk(OFS_STATUS, 32'h2, 32'h0);
        wr(OFS_CLKSRC, 32'h32);
        rdChk(OFS_CLKSRC, 32'hffffffff, 32'h32);
        for (int c = 2; c < 5; c++) begin
            for (int b = 0; b < 2; b++) begin
                wr(OFS_CTRL, 32'h20 | c);
                remote.send(c[2:0], {32{b[0]}}, 72, 1'b0);
                rdChk(OFS_RXDATA, 32'hffffffff, {32{b[0]}});
                rdChk(OFS_STATUS, 32'h4, 32'h4);
                repeat (10) @(posedge sysClk);
            end
        end
        reportAndStop();
    end
    // Counts cycles and cuts a hung run short.
    always @(posedge sysClk) begin
        cycles++;
        if (cycles == 40000) begin
            errTotal++;
            reportAndStop();
        end
    end
endmodule
